// ==== core/ulc_line_ctrl.sv ====
// UART with line-control options behind a classic Wishbone slave.
// Assumes pins are asynchronous to i_mclk; pads resolve tri-states.
//
// Design decisions made here: the register addresses and the Wishbone register port.
`include "ulc_regs.svh"
module ulc_line_ctrl
  import ulc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Serial line
  input wire logic i_rx,
  input wire logic i_cts_n,
  output logic o_tx,
  output logic o_tx_oe,
  output logic o_rts_n,
  output logic o_rts_oe,
  output logic o_de,
  // Open-drain interrupt pin
  input wire logic i_irq_n,
  output logic o_irq_n,
  output logic o_irq_n_oe
);

  function automatic logic is_adr(input logic [7:0] a, input logic [7:0] r);
    is_adr = (a == r);
  endfunction : is_adr

  // Bus and register group
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [7:0] isr_q, isr_d, ien_q, ien_d;
  logic [7:0] first_mode_reg_q, first_mode_reg_d, second_mode_reg_q, second_mode_reg_d;
  logic [1:0] flow_q, flow_d;
  logic ready_q, ready_d;
  logic irq_oe_q, irq_oe_d;
  logic txoe_q, txoe_d, rtsoe_q, rtsoe_d;
  logic req, wr, rd, wr_txd, rd_rxd;

  // Line group
  logic rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q, cts_s3_q;
  logic irq_s1_q, irq_s2_q;
  ulc_tx_st_t tx_st_q, tx_st_d;
  ulc_rx_st_t rx_st_q, rx_st_d;
  logic [15:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_dat_q, rx_dat_d, tx_hold_q, tx_hold_d;
  logic rx_full_q, rx_full_d, tx_full_q, tx_full_d;
  logic echo_pend_q, echo_pend_d;
  logic tx_o_q, tx_o_d, rts_q, rts_d, de_q, de_d;
  logic ev_tx, ev_rx, rx_done, flow_auto;

  assign req = i_wb_cyc & i_wb_stb;
  // Writes and read side effects land on the edge the master sees ack
  assign wr = req & i_wb_we & ack_q & i_wb_sel[0];
  assign rd = req & ~i_wb_we & ack_q;
  assign wr_txd = wr & is_adr(i_wb_adr, `ULC_ADR_TXD);
  assign rd_rxd = rd & is_adr(i_wb_adr, `ULC_ADR_RXD);
  assign flow_auto = (flow_q == `ULC_FLOW_AUTO);

  always_comb begin
    ack_d = req & ~ack_q;
    dat_d = dat_q;
    if (req && !ack_q) begin
      dat_d = 32'h0000_0000;
      case (i_wb_adr)
        `ULC_ADR_ISR: dat_d[7:0] = isr_q;
        `ULC_ADR_IEN: dat_d[7:0] = ien_q;
        `ULC_ADR_FIRST_MODE_REG: dat_d[7:0] = first_mode_reg_q;
        `ULC_ADR_SECOND_MODE_REG: dat_d[7:0] = second_mode_reg_q;
        `ULC_ADR_FLOW: dat_d[1:0] = flow_q;
        `ULC_ADR_REV: dat_d[7:0] = `ULC_REV_ID;
        `ULC_ADR_STAT: dat_d[3:0] = {irq_s2_q, cts_s2_q, rx_full_q,
                                     tx_full_q | (tx_st_q != TX_IDLE)};
        `ULC_ADR_RXD: dat_d[7:0] = rx_dat_q;
        default: dat_d = 32'h0000_0000;
      endcase
    end
    ien_d = ien_q;
    first_mode_reg_d = first_mode_reg_q;
    second_mode_reg_d = second_mode_reg_q;
    flow_d = flow_q;
    isr_d = isr_q;
    if (wr && is_adr(i_wb_adr, `ULC_ADR_IEN))
      ien_d = i_wb_dat[7:0];
    if (wr && is_adr(i_wb_adr, `ULC_ADR_FIRST_MODE_REG))
      first_mode_reg_d = i_wb_dat[7:0];
    if (wr && is_adr(i_wb_adr, `ULC_ADR_SECOND_MODE_REG))
      second_mode_reg_d = i_wb_dat[7:0];
    if (wr && is_adr(i_wb_adr, `ULC_ADR_FLOW))
      flow_d = i_wb_dat[1:0];
    // Write one to clear; a same-cycle event wins over the clear
    if (wr && is_adr(i_wb_adr, `ULC_ADR_ISR))
      isr_d = isr_q & ~i_wb_dat[7:0];
    ready_d = 1'b1;
    isr_d[`ULC_ISR_READY] = isr_d[`ULC_ISR_READY] | ~ready_q;
    isr_d[`ULC_ISR_TXDONE] = isr_d[`ULC_ISR_TXDONE] | ev_tx;
    isr_d[`ULC_ISR_RXRDY] = isr_d[`ULC_ISR_RXRDY] | ev_rx;
    isr_d[`ULC_ISR_CTS] = isr_d[`ULC_ISR_CTS] | (cts_s2_q ^ cts_s3_q);
    irq_oe_d = |(isr_q & ien_q);
    txoe_d = ~first_mode_reg_d[`ULC_M1_TXZ];
    rtsoe_d = ~first_mode_reg_d[`ULC_M1_RTSZ];
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      isr_q <= `ULC_RST_REG;
      ien_q <= `ULC_RST_REG;
      first_mode_reg_q <= `ULC_RST_REG;
      second_mode_reg_q <= `ULC_RST_REG;
      flow_q <= 2'h0;
      ready_q <= 1'b0;
      irq_oe_q <= 1'b0;
      txoe_q <= 1'b1;
      rtsoe_q <= 1'b1;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      isr_q <= isr_d;
      ien_q <= ien_d;
      first_mode_reg_q <= first_mode_reg_d;
      second_mode_reg_q <= second_mode_reg_d;
      flow_q <= flow_d;
      ready_q <= ready_d;
      irq_oe_q <= irq_oe_d;
      txoe_q <= txoe_d;
      rtsoe_q <= rtsoe_d;
    end
  end

  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    tx_hold_d = tx_hold_q;
    tx_full_d = tx_full_q;
    echo_pend_d = echo_pend_q;
    ev_tx = 1'b0;
    // A character written while the holding byte is full is dropped
    if (wr_txd && !tx_full_q) begin
      tx_hold_d = i_wb_dat[7:0];
      tx_full_d = 1'b1;
    end
    case (tx_st_q)
      TX_IDLE: begin
        // Auto flow holds off the next character while CTS is high
        if (tx_full_q && !(flow_auto && cts_s2_q)) begin
          tx_st_d = TX_SHIFT;
          tx_sh_d = {1'b1, tx_hold_q, 1'b0};
          tx_cnt_d = 16'h0000;
          tx_bit_d = 4'h0;
          tx_full_d = 1'b0;
          echo_pend_d = 1'b1;
        end
      end
      TX_SHIFT: begin
        tx_cnt_d = tx_cnt_q + 16'h0001;
        if (tx_cnt_q == `ULC_BIT_CYC - 16'h0001) begin
          tx_cnt_d = 16'h0000;
          tx_sh_d = {1'b1, tx_sh_q[9:1]};
          tx_bit_d = tx_bit_q + 4'h1;
          if (tx_bit_q == 4'h9) begin
            tx_st_d = TX_IDLE;
            ev_tx = 1'b1;
          end
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
    tx_o_d = (tx_st_d == TX_SHIFT) ? tx_sh_d[0] : 1'b1;
    // Enable rises with the start bit and lasts one cycle past the stop bit
    de_d = first_mode_reg_q[`ULC_M1_DIR] &
           ((tx_st_d != TX_IDLE) | (tx_st_q != TX_IDLE));

    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_dat_d = rx_dat_q;
    rx_full_d = rx_full_q & ~rd_rxd;
    rx_done = 1'b0;
    ev_rx = 1'b0;
    case (rx_st_q)
      RX_IDLE: begin
        if (!rx_s2_q) begin
          rx_st_d = RX_BUSY;
          rx_cnt_d = `ULC_HALF_CYC;
          rx_bit_d = 4'h0;
        end
      end
      RX_BUSY: begin
        rx_cnt_d = rx_cnt_q - 16'h0001;
        if (rx_cnt_q == 16'h0000) begin
          rx_cnt_d = `ULC_BIT_CYC - 16'h0001;
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && rx_s2_q)
            rx_st_d = RX_IDLE;
          else if (rx_bit_q != 4'h0 && rx_bit_q != 4'h9)
            rx_sh_d = {rx_s2_q, rx_sh_q[7:1]};
          else if (rx_bit_q == 4'h9) begin
            rx_st_d = RX_IDLE;
            rx_done = rx_s2_q;
          end
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
    if (rx_done) begin
      // A character starting in this cycle keeps its own echo pending
      echo_pend_d = (tx_st_q == TX_IDLE) && (tx_st_d == TX_SHIFT);
      // Own echoed character is discarded only while the second mode register's echo bit is set
      if (!(second_mode_reg_q[`ULC_M2_ECHO] && echo_pend_q)) begin
        rx_dat_d = rx_sh_q;
        rx_full_d = 1'b1;
        ev_rx = 1'b1;
      end
    end
    // Auto RTS deasserts while the receive byte is unread
    rts_d = flow_auto & rx_full_d;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
      cts_s3_q <= 1'b1;
      irq_s1_q <= 1'b1;
      irq_s2_q <= 1'b1;
      tx_st_q <= TX_IDLE;
      rx_st_q <= RX_IDLE;
      tx_cnt_q <= 16'h0000;
      rx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      rx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3FF;
      rx_sh_q <= 8'h00;
      rx_dat_q <= 8'h00;
      tx_hold_q <= 8'h00;
      rx_full_q <= 1'b0;
      tx_full_q <= 1'b0;
      echo_pend_q <= 1'b0;
      tx_o_q <= 1'b1;
      rts_q <= 1'b0;
      de_q <= 1'b0;
    end else begin
      rx_s1_q <= i_rx;
      rx_s2_q <= rx_s1_q;
      cts_s1_q <= i_cts_n;
      cts_s2_q <= cts_s1_q;
      cts_s3_q <= cts_s2_q;
      irq_s1_q <= i_irq_n;
      irq_s2_q <= irq_s1_q;
      tx_st_q <= tx_st_d;
      rx_st_q <= rx_st_d;
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      tx_bit_q <= tx_bit_d;
      rx_bit_q <= rx_bit_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      rx_dat_q <= rx_dat_d;
      tx_hold_q <= tx_hold_d;
      rx_full_q <= rx_full_d;
      tx_full_q <= tx_full_d;
      echo_pend_q <= echo_pend_d;
      tx_o_q <= tx_o_d;
      rts_q <= rts_d;
      de_q <= de_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = dat_q;
  assign o_tx = tx_o_q;
  assign o_tx_oe = txoe_q;
  assign o_rts_n = rts_q;
  assign o_rts_oe = rtsoe_q;
  assign o_de = de_q;
  // Open drain: the data level is always low, only the enable moves
  assign o_irq_n = 1'b0;
  assign o_irq_n_oe = irq_oe_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_isr_rx;
    ev_rx |=> isr_q[`ULC_ISR_RXRDY];
  endproperty
  a_isr_rx: assert property (p_isr_rx)
    else $error("received char not flagged in status");

  property p_irq_low;
    (ien_q[`ULC_ISR_TXDONE] && ev_tx) |=> ##1 o_irq_n_oe && !o_irq_n;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt not pulled low after enabled event");

  property p_irq_rel;
    !(|(isr_q & ien_q)) |=> !o_irq_n_oe;
  endproperty
  a_irq_rel: assert property (p_irq_rel)
    else $error("interrupt held with nothing pending");

  property p_txz;
    (wr && is_adr(i_wb_adr, `ULC_ADR_FIRST_MODE_REG) && i_wb_dat[`ULC_M1_TXZ])
      |=> !o_tx_oe;
  endproperty
  a_txz: assert property (p_txz)
    else $error("transmit pin still driven after tristate write");

  property p_rtsz;
    (wr && is_adr(i_wb_adr, `ULC_ADR_FIRST_MODE_REG) && i_wb_dat[`ULC_M1_RTSZ])
      |=> !o_rts_oe;
  endproperty
  a_rtsz: assert property (p_rtsz)
    else $error("rts pin still driven after tristate write");

  property p_cts_hold;
    (flow_auto && cts_s2_q && tx_st_q == TX_IDLE) |=> tx_st_q == TX_IDLE;
  endproperty
  a_cts_hold: assert property (p_cts_hold)
    else $error("transmit started while cts deasserted");

  property p_rts_full;
    (flow_auto && rx_full_q && !rd_rxd) |=> o_rts_n;
  endproperty
  a_rts_full: assert property (p_rts_full)
    else $error("rts asserted while receive byte unread");

  property p_echo;
    (rx_done && second_mode_reg_q[`ULC_M2_ECHO] && echo_pend_q && !rx_full_q)
      |=> !rx_full_q;
  endproperty
  a_echo: assert property (p_echo)
    else $error("echoed character was not discarded");

  property p_de;
    (first_mode_reg_q[`ULC_M1_DIR] && tx_st_q == TX_SHIFT) |=> o_de;
  endproperty
  a_de: assert property (p_de)
    else $error("driver enable low during transmission");

endmodule : ulc_line_ctrl

// ==== core/ulc_regs.svh ====
// Register map, field positions, reset values and timing counts.
// Assumes a 40 MHz core clock and 8-bit registers on 32-bit words.
`ifndef ULC_REGS_SVH
`define ULC_REGS_SVH
`define ULC_ADR_ISR 8'h00
`define ULC_ADR_IEN 8'h04
`define ULC_ADR_FIRST_MODE_REG 8'h08
`define ULC_ADR_SECOND_MODE_REG 8'h0C
`define ULC_ADR_FLOW 8'h10
`define ULC_ADR_REV 8'h14
`define ULC_ADR_STAT 8'h18
`define ULC_ADR_TXD 8'h1C
`define ULC_ADR_RXD 8'h20
`define ULC_M1_TXZ 2
`define ULC_M1_RTSZ 3
`define ULC_M1_DIR 4
`define ULC_M2_ECHO 7
`define ULC_FLOW_AUTO 2'h3
`define ULC_ISR_READY 0
`define ULC_ISR_TXDONE 1
`define ULC_ISR_RXRDY 2
`define ULC_ISR_CTS 3
`define ULC_RST_REG 8'h00
// Revision value is arbitrary
`define ULC_REV_ID 8'h51
`define ULC_CLK_HZ 40000000
`define ULC_BAUD 115200
`define ULC_BIT_CYC 16'((`ULC_CLK_HZ) / (`ULC_BAUD))
`define ULC_HALF_CYC 16'((`ULC_CLK_HZ) / (`ULC_BAUD) / 2)
`endif

// ==== core/ulc_pkg.sv ====
// State types of the line-control UART block.
// Assumes ulc_regs.svh supplies all numeric constants.
package ulc_pkg;
  typedef enum logic {TX_IDLE, TX_SHIFT} ulc_tx_st_t;
  typedef enum logic {RX_IDLE, RX_BUSY} ulc_rx_st_t;
endpackage : ulc_pkg

// ==== tb/ulc_xcvr.sv ====
// Half-duplex line transceiver whose receiver is always enabled.
// Assumes the bench drives the far line and reads the resolved wire.
module ulc_xcvr (
  // Device side
  input wire logic i_di,
  input wire logic i_di_oe,
  input wire logic i_de,
  // Far side
  input wire logic i_line,
  output logic o_ro
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driver output reaches the wire only while enabled and driven, so the
  // device hears its own characters back as an echo
  always_comb begin
    o_ro = (i_de && i_di_oe) ? i_di : i_line;
  end
endmodule : ulc_xcvr

// ==== tb/tb.sv ====
// Self-checking bench for the line-control UART over classic Wishbone.
// Assumes one 40 MHz clock and a pull-up on the interrupt wire.
`include "ulc_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 0, i_rst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, o_wb_dat;
  logic o_wb_ack, rx_w, cts_n = 0, line = 1, o_tx, o_tx_oe, o_rts_n;
  logic o_rts_oe, o_de, o_irq_n, o_irq_n_oe, irq_w;
  logic [7:0] b, got;
  int err_total = 0, total_checks = 0, seed = 32'hC4A9, n;
  // One modest clock and no multiplier keeps the device's power low
  initial forever #12.5 i_mclk = ~i_mclk;
  // Pull-up supplies the released level of the open-drain wire
  assign irq_w = o_irq_n_oe ? o_irq_n : 1'b1;
  ulc_line_ctrl i_ulc_line_ctrl (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_rx(rx_w), .i_cts_n(cts_n), .o_tx(o_tx),
    .o_tx_oe(o_tx_oe), .o_rts_n(o_rts_n), .o_rts_oe(o_rts_oe),
    .o_de(o_de), .i_irq_n(irq_w), .o_irq_n(o_irq_n),
    .o_irq_n_oe(o_irq_n_oe));
  ulc_xcvr i_ulc_xcvr (.i_di(o_tx), .i_di_oe(o_tx_oe), .i_de(o_de),
    .i_line(line), .o_ro(rx_w));
  task automatic conclude;
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge i_mclk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge i_mclk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 50);
    rdat = o_wb_dat;
    cyc <= 0;
    stb <= 0;
    if (k >= 50) begin
      err_total++;
      conclude();
    end
  endtask : wb
  task automatic tick(input int c);
    repeat (c) @(posedge i_mclk);
  endtask : tick
  // Waits for a start bit, then samples each bit at its centre
  task automatic catch_char(output logic [7:0] v);
    int k;
    k = 0;
    while (o_tx !== 1'b0 && k < 2000) begin
      @(posedge i_mclk);
      k++;
    end
    if (k >= 2000) begin
      err_total++;
      conclude();
    end
    tick(`ULC_HALF_CYC);
    chk(o_tx, 0);
    for (int i = 0; i < 8; i++) begin
      tick(`ULC_BIT_CYC);
      v[i] = o_tx;
    end
    tick(`ULC_BIT_CYC);
    chk(o_tx, 1);
  endtask : catch_char
  // Far end of the line sends one 8N1 character
  task automatic drive_char(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      tick(`ULC_BIT_CYC);
    end
  endtask : drive_char
  task automatic send(input logic [7:0] d, input logic ech);
    wb(1, `ULC_ADR_SECOND_MODE_REG, {ech, 7'h0});
    wb(1, `ULC_ADR_ISR, 8'hFF);
    tick(2);
    chk(irq_w, 1);
    wb(1, `ULC_ADR_TXD, d);
    tick(3);
    chk(o_de, 1);
    catch_char(got);
    chk(got, d);
    tick(2 * `ULC_BIT_CYC);
    chk(o_de, 0);
    wb(0, `ULC_ADR_ISR, 0);
    chk(rdat[2:1], {!ech, 1'b1});
    chk(irq_w, 0);
  endtask : send
  initial begin
    tick(20);
    i_rst <= 0;
    n = 0;
    do begin
      wb(0, `ULC_ADR_REV, 0);
      n++;
    end while (rdat[7:4] !== 4'(`ULC_REV_ID >> 4) && n < 8);
    chk(rdat[7:4], 4'(`ULC_REV_ID >> 4));
    wb(0, `ULC_ADR_ISR, 0);
    chk(rdat[0], 1);
    chk(irq_w, 1);
    wb(0, 8'hFC, 0);
    chk(rdat, 0);
    wb(1, `ULC_ADR_IEN, 8'h01);
    tick(4);
    chk(irq_w, 0);
    wb(0, `ULC_ADR_STAT, 0);
    chk(rdat[3], 0);
    wb(1, `ULC_ADR_ISR, 8'h01);
    tick(4);
    chk(irq_w, 1);
    for (int i = 0; i < 8; i++) begin
      b = 8'($random(seed)) & 8'hEF;
      b = (i < 4) ? (b & 8'hF3) | 8'(i << 2) : b;
      wb(1, `ULC_ADR_FIRST_MODE_REG, b);
      tick(3);
      chk(o_tx_oe, !b[2]);
      chk(o_rts_oe, !b[3]);
    end
    wb(1, `ULC_ADR_FIRST_MODE_REG, 8'h10);
    wb(1, `ULC_ADR_IEN, 8'h02);
    b = 8'($random(seed));
    send(b, 1);
    wb(0, `ULC_ADR_STAT, 0);
    chk(rdat[1], 0);
    b = 8'($random(seed));
    send(b, 0);
    wb(0, `ULC_ADR_RXD, 0);
    chk(rdat[7:0], b);
    wb(1, `ULC_ADR_FIRST_MODE_REG, 8'h00);
    wb(1, `ULC_ADR_FLOW, `ULC_FLOW_AUTO);
    cts_n <= 1;
    tick(4);
    b = 8'($random(seed));
    wb(1, `ULC_ADR_TXD, b);
    n = 0;
    repeat (1000) begin
      @(posedge i_mclk);
      n += (o_tx !== 1'b1);
    end
    chk(n, 0);
    chk(o_de, 0);
    cts_n <= 0;
    catch_char(got);
    chk(got, b);
    b = 8'($random(seed));
    drive_char(b);
    tick(4);
    chk(o_rts_n, 1);
    wb(0, `ULC_ADR_RXD, 0);
    chk(rdat[7:0], b);
    tick(2);
    chk(o_rts_n, 0);
    i_rst <= 1;
    tick(2);
    i_rst <= 0;
    wb(0, `ULC_ADR_ISR, 0);
    chk(rdat[0], 1);
    chk(irq_w, 1);
    chk(o_tx_oe, 1);
    conclude();
  end
endmodule : tb
